// ---- mjw_top.sv ----
`timescale 1ns/1ps
module mjw_top #(
  parameter int JAB_CYC_100  = mjw_pkg::JAB_CYC_100,
  parameter int JAB_CYC_10   = mjw_pkg::JAB_CYC_10,
  parameter int HOLD_CYC_100 = mjw_pkg::HOLD_CYC_100,
  parameter int HOLD_CYC_10  = mjw_pkg::HOLD_CYC_10
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        speed_100,
  input  wire logic        carrier_sense,
  input  wire logic        rx_byte_strobe,
  input  wire logic        tx_active,
  input  wire logic        tx_byte_strobe,
  input  wire logic        tx_to_fifo_done,
  input  wire logic        rx_first_desc_full,
  input  wire logic [6:0]  transceiver_interrupt_reg,
  input  wire logic        tx_deferred_event,
  input  wire logic        pause_frame_event,
  input  wire logic        pause_enabled,
  input  wire logic [2:0]  bus_error_kind_in,
  input  wire logic [2:0]  transmit_engine_state_in,
  input  wire logic [2:0]  receive_engine_state_in,
  input  wire logic [14:0] primary_status_set,
  output logic             rx_watchdog_expired,
  output logic             tx_jabber_cutoff,
  output logic             irq
);

  // Shared decode of a byte offset to a word match
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  logic [31:0] ctrl_reg;
  logic [31:0] aux_en_reg;
  logic [31:0] aux_flags_reg;      // Latched bits 31..28,26,16,15
  logic [14:0] primary_low_reg;
  logic [mjw_pkg::EV_W-1:0] irq_stat_reg;
  logic [mjw_pkg::EV_W-1:0] irq_en_reg;
  logic [2:0]  carrier_sync_reg;
  logic [31:0] rx_cnt_reg;
  logic [31:0] rel_cnt_reg;
  logic [31:0] jab_cnt_reg;
  logic [31:0] hold_cnt_reg;
  logic        carrier_q;
  logic        rx_active_reg;
  logic        xcvr_q;

  // AXI write path
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic        wr_fire;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held     <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held     <= 1'b1;
        w_data_reg <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                     {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (hit(aw_addr_reg, mjw_pkg::WDOG_JABBER_CTRL_OFF) ||
                         hit(aw_addr_reg, mjw_pkg::AUX_STATUS_OFF) ||
                         hit(aw_addr_reg, mjw_pkg::AUX_ENABLE_OFF) ||
                         hit(aw_addr_reg, mjw_pkg::PRIMARY_STATUS_OFF) ||
                         hit(aw_addr_reg, mjw_pkg::IRQ_STATUS_OFF) ||
                         hit(aw_addr_reg, mjw_pkg::IRQ_CLEAR_OFF) ||
                         hit(aw_addr_reg, mjw_pkg::IRQ_ENABLE_OFF))
                        ? mjw_pkg::RESP_OKAY : mjw_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Write strobes per register
  logic wr_ctrl;
  logic wr_aux;
  logic wr_en;
  logic wr_prim;
  logic wr_iclr;
  logic wr_ien;
  assign wr_ctrl = wr_fire && hit(aw_addr_reg, mjw_pkg::WDOG_JABBER_CTRL_OFF);
  assign wr_aux  = wr_fire && hit(aw_addr_reg, mjw_pkg::AUX_STATUS_OFF);
  assign wr_en   = wr_fire && hit(aw_addr_reg, mjw_pkg::AUX_ENABLE_OFF);
  assign wr_prim = wr_fire && hit(aw_addr_reg, mjw_pkg::PRIMARY_STATUS_OFF);
  assign wr_iclr = wr_fire && hit(aw_addr_reg, mjw_pkg::IRQ_CLEAR_OFF);
  assign wr_ien  = wr_fire && hit(aw_addr_reg, mjw_pkg::IRQ_ENABLE_OFF);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg   <= mjw_pkg::CTRL_RESET;
      aux_en_reg <= 32'h0000_0000;
      irq_en_reg <= '0;
    end else begin
      if (wr_ctrl) ctrl_reg <= w_data_reg & mjw_pkg::CTRL_MASK;
      if (wr_en) aux_en_reg <= w_data_reg & mjw_pkg::AUX_ENABLE_MASK;
      if (wr_ien) irq_en_reg <= w_data_reg[mjw_pkg::EV_W-1:0];
    end
  end

  // Carrier sense synchroniser, three stages
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carrier_sync_reg <= 3'h0;
      carrier_q        <= 1'b0;
    end else begin
      carrier_sync_reg <= {carrier_sync_reg[1:0], carrier_sense};
      if (carrier_sync_reg[1] == carrier_sync_reg[2]) carrier_q <= carrier_sync_reg[2];
    end
  end

  // Bit-time cycle counts at current speed
  logic [31:0] bit_cyc;
  logic [31:0] rel_lim;
  logic [31:0] jab_lim;
  logic [31:0] hold_lim;
  assign bit_cyc = speed_100 ? 32'(mjw_pkg::BIT_CYC_100) : 32'(mjw_pkg::BIT_CYC_10);
  assign rel_lim = ctrl_reg[mjw_pkg::RELEASE_SEL_BIT]
                   ? 32'(mjw_pkg::REL_LONG_BITS) * bit_cyc
                   : 32'(mjw_pkg::REL_SHORT_BITS) * bit_cyc;
  assign jab_lim = speed_100 ? 32'(JAB_CYC_100) : 32'(JAB_CYC_10);
  assign hold_lim = speed_100 ? 32'(HOLD_CYC_100) : 32'(HOLD_CYC_10);

  // Receive watchdog
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_cnt_reg          <= 32'h0000_0000;
      rel_cnt_reg         <= 32'h0000_0000;
      rx_active_reg       <= 1'b0;
      rx_watchdog_expired <= 1'b0;
    end else if (ctrl_reg[mjw_pkg::RX_WDOG_OFF_BIT]) begin
      rx_cnt_reg          <= 32'h0000_0000;
      rel_cnt_reg         <= 32'h0000_0000;
      rx_active_reg       <= 1'b0;
      rx_watchdog_expired <= 1'b0;
    end else if (carrier_q) begin
      rel_cnt_reg   <= 32'h0000_0000;
      rx_active_reg <= 1'b1;
      if (rx_byte_strobe) begin
        rx_cnt_reg <= rx_cnt_reg + 32'h0000_0001;
        if (rx_cnt_reg >= 32'(mjw_pkg::RX_WDOG_BYTES)) rx_watchdog_expired <= 1'b1;
      end
    end else if (rx_active_reg) begin
      rel_cnt_reg <= rel_cnt_reg + 32'h0000_0001;
      if (rel_cnt_reg + 32'h0000_0001 >= rel_lim) begin
        rx_active_reg       <= 1'b0;
        rx_cnt_reg          <= 32'h0000_0000;
        rx_watchdog_expired <= 1'b0;
      end
    end
  end

  // Transmit jabber and holdoff
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      jab_cnt_reg      <= 32'h0000_0000;
      hold_cnt_reg     <= 32'h0000_0000;
      tx_jabber_cutoff <= 1'b0;
    end else if (ctrl_reg[mjw_pkg::JAB_OFF_BIT]) begin
      jab_cnt_reg      <= 32'h0000_0000;
      hold_cnt_reg     <= 32'h0000_0000;
      tx_jabber_cutoff <= 1'b0;
    end else if (tx_jabber_cutoff) begin
      hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
      if (ctrl_reg[mjw_pkg::JAB_NO_HOLD_BIT] || hold_cnt_reg + 32'h0000_0001 >= hold_lim) begin
        tx_jabber_cutoff <= 1'b0;
        hold_cnt_reg     <= 32'h0000_0000;
        jab_cnt_reg      <= 32'h0000_0000;
      end
    end else if (tx_active) begin
      if (ctrl_reg[mjw_pkg::JAB_TIMEBASE_BIT]) begin
        if (tx_byte_strobe) jab_cnt_reg <= jab_cnt_reg + 32'h0000_0001;
        if (jab_cnt_reg >= 32'(mjw_pkg::JAB_BYTES)) tx_jabber_cutoff <= 1'b1;
      end else begin
        jab_cnt_reg <= jab_cnt_reg + 32'h0000_0001;
        if (jab_cnt_reg + 32'h0000_0001 >= jab_lim) tx_jabber_cutoff <= 1'b1;
      end
    end else begin
      jab_cnt_reg <= 32'h0000_0000;
    end
  end

  // Latched flag set terms
  logic [31:0] flag_set;
  logic        xcvr_now;
  logic        norm_any;
  logic        abn_any;
  assign xcvr_now = |transceiver_interrupt_reg;
  always_comb begin
    flag_set = 32'h0000_0000;
    flag_set[mjw_pkg::TX_EARLY_BIT] = tx_to_fifo_done && aux_en_reg[mjw_pkg::TX_EARLY_BIT];
    flag_set[mjw_pkg::RX_EARLY_BIT] = rx_first_desc_full && aux_en_reg[mjw_pkg::RX_EARLY_BIT];
    flag_set[mjw_pkg::XCVR_BIT]     = xcvr_now && !xcvr_q;
    flag_set[mjw_pkg::TX_DEFER_BIT] = tx_deferred_event;
    flag_set[mjw_pkg::PAUSE_BIT]    = pause_frame_event && pause_enabled;
  end
  assign norm_any = flag_set[mjw_pkg::TX_EARLY_BIT] | flag_set[mjw_pkg::RX_EARLY_BIT];
  assign abn_any  = flag_set[mjw_pkg::XCVR_BIT] | flag_set[mjw_pkg::TX_DEFER_BIT]
                  | flag_set[mjw_pkg::PAUSE_BIT];

  // latch high, write one clears, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_flags_reg <= 32'h0000_0000;
      xcvr_q        <= 1'b0;
    end else begin
      xcvr_q <= xcvr_now;
      aux_flags_reg <= (aux_flags_reg & ~(wr_aux ? w_data_reg : 32'h0000_0000)) | flag_set;
      if (norm_any) aux_flags_reg[mjw_pkg::ADD_NORMAL_BIT] <= 1'b1;
      if (abn_any) aux_flags_reg[mjw_pkg::ADD_ABNORM_BIT] <= 1'b1;
    end
  end

  // shared low status bits, either address clears
  logic [14:0] low_clear;
  logic [14:0] prim_set;
  assign low_clear = wr_aux ? w_data_reg[14:0] : (wr_prim ? w_data_reg[14:0] : 15'h0000);
  always_comb begin
    prim_set = primary_status_set;
    if (aux_en_reg[mjw_pkg::ADD_NORMAL_BIT] && norm_any) prim_set[14] = 1'b1;
    // added abnormal flags feed shared low bit 14
    if (aux_en_reg[mjw_pkg::ADD_ABNORM_BIT] && abn_any) prim_set[mjw_pkg::ABNORM_SUM_BIT-1] = 1'b1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) primary_low_reg <= 15'h0000;
    else primary_low_reg <= (primary_low_reg & ~low_clear) | (prim_set & mjw_pkg::LOW_MASK);
  end

  // Block interrupt status, clear and enable
  logic [mjw_pkg::EV_W-1:0] ev_set;
  assign ev_set = {norm_any | abn_any, tx_jabber_cutoff, rx_watchdog_expired};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~(wr_iclr ? w_data_reg[mjw_pkg::EV_W-1:0] : '0)) | ev_set;
      irq <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // Auxiliary status readback
  logic [31:0] aux_view;
  always_comb begin
    aux_view = aux_flags_reg & mjw_pkg::AUX_ENABLE_MASK;
    aux_view[mjw_pkg::BUS_ERR_LSB +: 3] = bus_error_kind_in;
    aux_view[mjw_pkg::TX_STATE_LSB +: 3] = transmit_engine_state_in;
    aux_view[mjw_pkg::RX_STATE_LSB +: 3] = receive_engine_state_in;
    aux_view[14:0] = primary_low_reg;
  end

  // AXI read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mjw_pkg::RESP_OKAY;
        if (hit(s_axi_araddr, mjw_pkg::WDOG_JABBER_CTRL_OFF)) s_axi_rdata <= ctrl_reg;
        else if (hit(s_axi_araddr, mjw_pkg::AUX_STATUS_OFF)) s_axi_rdata <= aux_view;
        else if (hit(s_axi_araddr, mjw_pkg::AUX_ENABLE_OFF)) s_axi_rdata <= aux_en_reg;
        else if (hit(s_axi_araddr, mjw_pkg::PRIMARY_STATUS_OFF))
          s_axi_rdata <= {17'h00000, primary_low_reg};
        else if (hit(s_axi_araddr, mjw_pkg::IRQ_STATUS_OFF))
          s_axi_rdata <= {29'h0000_0000, irq_stat_reg};
        else if (hit(s_axi_araddr, mjw_pkg::IRQ_ENABLE_OFF))
          s_axi_rdata <= {29'h0000_0000, irq_en_reg};
        else if (hit(s_axi_araddr, mjw_pkg::IRQ_CLEAR_OFF)) s_axi_rdata <= 32'h0000_0000;
        else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= mjw_pkg::RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  chk_flag_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    flag_set[mjw_pkg::PAUSE_BIT] |=> aux_flags_reg[mjw_pkg::PAUSE_BIT])
    else $error("pause flag not latched");
  chk_tx_early_set: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_to_fifo_done && aux_en_reg[31] |=> aux_flags_reg[31] && aux_flags_reg[16])
    else $error("transmit early flag missing");
  chk_rx_early_set: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_first_desc_full && aux_en_reg[30] |=> aux_flags_reg[30])
    else $error("receive early flag missing");
  chk_abn_summary: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_deferred_event |=> aux_flags_reg[mjw_pkg::ADD_ABNORM_BIT])
    else $error("abnormal summary missing");
  chk_jab_off: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(ctrl_reg[0]) && ctrl_reg[0] |-> !tx_jabber_cutoff)
    else $error("jabber cut while disabled");
  chk_no_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_jabber_cutoff && ctrl_reg[1] && !ctrl_reg[0] |=> !tx_jabber_cutoff)
    else $error("no-holdoff not immediate");
  chk_wdog_off: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_reg[4] |=> !rx_watchdog_expired)
    else $error("watchdog active while off");
  chk_ctrl_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_reg & ~mjw_pkg::CTRL_MASK) == 32'h0000_0000)
    else $error("reserved control bit set");

endmodule // mjw_top

// ---- mjw_pkg.sv ----
package mjw_pkg;
  // Register byte offsets
  localparam logic [7:0] WDOG_JABBER_CTRL_OFF = 8'h78;
  localparam logic [7:0] AUX_STATUS_OFF       = 8'h80;
  localparam logic [7:0] AUX_ENABLE_OFF       = 8'h84;
  localparam logic [7:0] PRIMARY_STATUS_OFF   = 8'h28;
  localparam logic [7:0] IRQ_STATUS_OFF       = 8'hA0;
  localparam logic [7:0] IRQ_CLEAR_OFF        = 8'hA4;
  localparam logic [7:0] IRQ_ENABLE_OFF       = 8'hA8;
  // Control field positions
  localparam int RELEASE_SEL_BIT  = 5;
  localparam int RX_WDOG_OFF_BIT  = 4;
  localparam int JAB_TIMEBASE_BIT = 2;
  localparam int JAB_NO_HOLD_BIT  = 1;
  localparam int JAB_OFF_BIT      = 0;
  localparam logic [31:0] CTRL_MASK  = 32'h0000_0037;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Auxiliary status field positions
  localparam int TX_EARLY_BIT    = 31;
  localparam int RX_EARLY_BIT    = 30;
  localparam int XCVR_BIT        = 29;
  localparam int TX_DEFER_BIT    = 28;
  localparam int PAUSE_BIT       = 26;
  localparam int BUS_ERR_LSB     = 23;
  localparam int TX_STATE_LSB    = 20;
  localparam int RX_STATE_LSB    = 17;
  localparam int ADD_NORMAL_BIT  = 16;
  localparam int ADD_ABNORM_BIT  = 15;
  localparam int FATAL_BUS_BIT   = 13;
  localparam int NORMAL_SUM_BIT  = 16;
  localparam int ABNORM_SUM_BIT  = 15;
  localparam logic [31:0] AUX_ENABLE_MASK = 32'hF401_8000;
  localparam logic [14:0] LOW_MASK        = 15'h7FFF;
  // Bus error kinds
  localparam logic [2:0] BERR_PARITY = 3'h0;
  localparam logic [2:0] BERR_MABORT = 3'h1;
  localparam logic [2:0] BERR_TABORT = 3'h2;
  // Block interrupt status bits
  localparam int EV_RX_WDOG = 0;
  localparam int EV_JABBER  = 1;
  localparam int EV_AUX     = 2;
  localparam int EV_W       = 3;
  // Timing, 10 ns clock
  localparam int CLK_PS           = 10000;
  localparam int BIT_PS_100       = 10000;
  localparam int BIT_PS_10        = 100000;
  localparam int REL_SHORT_BITS   = 24;
  localparam int REL_LONG_BITS    = 48;
  localparam int RX_WDOG_BYTES    = 2560;
  localparam int JAB_BYTES        = 2560;
  localparam int JAB_US_100       = 2600;
  localparam int JAB_US_10        = 26000;
  localparam int HOLD_US_100      = 42000;
  localparam int HOLD_US_10       = 420000;
  localparam int BIT_CYC_100 = (BIT_PS_100 + CLK_PS - 1) / CLK_PS;
  localparam int BIT_CYC_10  = (BIT_PS_10 + CLK_PS - 1) / CLK_PS;
  localparam int JAB_CYC_100  = JAB_US_100 * 100;
  localparam int JAB_CYC_10   = JAB_US_10 * 100;
  localparam int HOLD_CYC_100 = HOLD_US_100 * 100;
  localparam int HOLD_CYC_10  = HOLD_US_10 * 100;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- test_mac_jabber_watchdog_status.sv ----
`timescale 1ns/1ps
module test_mac_jabber_watchdog_status;
  localparam logic [7:0] CTL = mjw_pkg::WDOG_JABBER_CTRL_OFF;
  localparam logic [7:0] AUX = mjw_pkg::AUX_STATUS_OFF;
  localparam logic [7:0] AEN = mjw_pkg::AUX_ENABLE_OFF;
  localparam logic [7:0] PRI = mjw_pkg::PRIMARY_STATUS_OFF;
  logic        aclk, aresetn, awv, wv, bre, arv, rre, awr, wr, bv, arr, rv;
  logic        spd, crs, rxb, txa, txb, pen, wdx, jab, irq;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  ev, stb;
  logic [6:0]  xir;
  logic [2:0]  be, ts, rs;
  logic [14:0] pss, r;
  logic [65:0] cur;
  logic [65:0] exp_q[$];
  logic [1:0]  exp_b[$];
  int          n_errors, num_checks, lim, hld;
  mjw_top #(.JAB_CYC_100(100), .JAB_CYC_10(200), .HOLD_CYC_100(150), .HOLD_CYC_10(300)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(stb), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre), .speed_100(spd),
    .carrier_sense(crs), .rx_byte_strobe(rxb), .tx_active(txa), .tx_byte_strobe(txb),
    .tx_to_fifo_done(ev[0]), .rx_first_desc_full(ev[1]), .transceiver_interrupt_reg(xir),
    .tx_deferred_event(ev[2]), .pause_frame_event(ev[3]), .pause_enabled(pen),
    .bus_error_kind_in(be), .transmit_engine_state_in(ts), .receive_engine_state_in(rs),
    .primary_status_set(pss), .rx_watchdog_expired(wdx), .tx_jabber_cutoff(jab), .irq(irq));
  // Clock source
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Verdict and end of run
  task automatic report_and_stop;
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Register write, address and data offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] br = 2'h0);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    exp_b.push_back(br);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awv && awr) begin ad = 1'b1; awv <= 1'b0; end
      if (wv && wr) begin dd = 1'b1; wv <= 1'b0; end
    end
    while (!bv) @(posedge aclk);
    bre <= 1'b0;
    // Let an edge pass so the next call never reassigns bready in this step
    @(posedge aclk);
  endtask
  // Register read, expectation noted first
  task automatic axr(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFF_FFFF, input logic [1:0] rr = 2'h0);
    exp_q.push_back({rr, m, e & m});
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    do @(posedge aclk); while (!arr);
    arv <= 1'b0;
    while (!rv) @(posedge aclk);
    rre <= 1'b0;
    // Let an edge pass so the next call never reassigns rready in this step
    @(posedge aclk);
  endtask
  // Event pulse of one cycle
  task automatic pls(input int i);
    ev[i] <= 1'b1;
    @(posedge aclk);
    ev[i] <= 1'b0;
    @(posedge aclk);
  endtask
  // Auxiliary word with live state fields
  function automatic logic [31:0] ax(input logic [31:0] f);
    return f | {6'h0, be, ts, rs, 17'h0};
  endfunction
  // Read results against oldest note
  always @(posedge aclk) begin
    if (rv && rre) begin
      cur = exp_q.pop_front();
      chk("rdata", cur[31:0], rdata & cur[63:32]);
      chk("rresp", {30'h0, cur[65:64]}, {30'h0, rresp});
    end
    if (bv && bre) chk("bresp", {30'h0, exp_b.pop_front()}, {30'h0, bresp});
  end
  // Hang guard
  initial begin
    #400000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(52945));
    {aresetn, awv, wv, bre, arv, rre, spd, crs, rxb, txa, txb, pen} = '0;
    stb = 4'hF;
    {awa, ara, wd, ev, xir, be, ts, rs, pss} = '0;
    cyc(12);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(CTL, 32'h0);
    // Unstrobed low lane writes zero
    stb <= 4'hE;
    axw(CTL, 32'hFFFF_FFFF);
    axr(CTL, 32'h0);
    stb <= 4'hF;
    axw(CTL, 32'hFFFF_FFFF);
    axr(CTL, mjw_pkg::CTRL_MASK);
    axw(8'h10, 32'hFFFF_FFFF, mjw_pkg::RESP_SLVERR);
    axr(8'h10, 32'h0, 32'hFFFF_FFFF, mjw_pkg::RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      be <= 3'($urandom_range(2)); ts <= i[2:0]; rs <= 3'(7 - i);
      cyc(4);
      axw(AUX, 32'h03FE_0000);
      axr(AUX, ax(32'h0));
    end
    // flags latch, zero keeps, one clears
    axw(AEN, mjw_pkg::AUX_ENABLE_MASK);
    pen <= 1'b1;
    for (int i = 0; i < 4; i++) pls(i);
    xir <= 7'(1 << $urandom_range(6));
    cyc(6);
    // Both summaries also set shared low bit 14
    axr(AUX, ax(32'hF401_C000));
    axr(PRI, 32'h4000, 32'h4000);
    axw(AUX, 32'h0);
    axr(AUX, ax(32'hF401_C000));
    axw(AUX, 32'h8000_0000);
    axr(AUX, ax(32'h7401_C000));
    axw(AUX, 32'hFFFF_FFFF);
    axr(AUX, ax(32'h0));
    axw(AEN, 32'h0);
    pen <= 1'b0;
    pls(0); pls(1); pls(3);
    axr(AUX, ax(32'h0));
    r = 15'($urandom) | 15'h1;
    pss <= r;
    @(posedge aclk);
    pss <= 15'h0;
    cyc(3);
    axr(AUX, ax({17'h0, r}));
    axw(AUX, 32'h7FFF);
    axr(PRI, 32'h0, 32'h7FFF);
    // cutoff and holdoff at both speeds
    axw(CTL, 32'h0);
    for (int s = 1; s >= 0; s--) begin
      spd <= s[0]; lim = s ? 100 : 200; hld = s ? 150 : 300;
      axw(mjw_pkg::IRQ_ENABLE_OFF, 32'(s * 2));
      txa <= 1'b1;
      cyc(lim - 10);
      chk("jab", 32'h0, {31'h0, jab});
      cyc(20);
      chk("jab", 32'h1, {31'h0, jab});
      chk("irq", 32'(s), {31'h0, irq});
      txa <= 1'b0;
      cyc(hld - 30);
      chk("jab", 32'h1, {31'h0, jab});
      cyc(40);
      chk("jab", 32'h0, {31'h0, jab});
      axr(mjw_pkg::IRQ_STATUS_OFF, 32'h2, 32'h2);
      axw(mjw_pkg::IRQ_CLEAR_OFF, 32'h7);
      cyc(2);
      chk("irq", 32'h0, {31'h0, irq});
    end
    spd <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      axw(CTL, k ? 32'h1 : 32'h2);
      txa <= 1'b1;
      cyc(k ? 250 : 110);
      txa <= 1'b0;
      cyc(5);
      chk("jab", 32'h0, {31'h0, jab});
      axr(mjw_pkg::IRQ_STATUS_OFF, k ? 32'h0 : 32'h2, 32'h2);
      axw(mjw_pkg::IRQ_CLEAR_OFF, 32'h7);
    end
    // byte-time base, one strobe each cycle
    axw(CTL, 32'h4);
    txa <= 1'b1;
    txb <= 1'b1;
    cyc(2550);
    chk("jab", 32'h0, {31'h0, jab});
    cyc(20);
    chk("jab", 32'h1, {31'h0, jab});
    txa <= 1'b0;
    txb <= 1'b0;
    cyc(160);
    chk("jab", 32'h0, {31'h0, jab});
    for (int k = 0; k < 3; k++) begin
      axw(CTL, k == 2 ? 32'h10 : 32'(k * 32));
      crs <= 1'b1; rxb <= 1'b1;
      cyc(2555);
      chk("wdog", 32'h0, {31'h0, wdx});
      cyc(12);
      chk("wdog", 32'(k < 2), {31'h0, wdx});
      rxb <= 1'b0; crs <= 1'b0;
      cyc((k ? 48 : 24) - 6);
      chk("wdog", 32'(k < 2), {31'h0, wdx});
      cyc(16);
      chk("wdog", 32'h0, {31'h0, wdx});
    end
    cyc(4);
    report_and_stop();
  end
endmodule // test_mac_jabber_watchdog_status
